// >>> src/fan_pwm_regs.svh
`ifndef FAN_PWM_REGS_SVH
`define FAN_PWM_REGS_SVH

// ==========================================================
// register byte offsets
`define ACOUSTIC_CFG_OFS 5'h00
`define SPAN_CFG_OFS 5'h04
`define BEHAV_CFG_OFS 5'h08
`define MAN_DUTY1_OFS 5'h0c
`define MAN_DUTY2_OFS 5'h10
`define MAN_DUTY3_OFS 5'h14
`define STATUS_OFS 5'h18

// ==========================================================
// reset values
`define ACOUSTIC_CFG_RST 8'h00
`define SPAN_CFG_RST 12'hccc
`define BEHAV_CFG_RST 9'h0db
`define MAN_DUTY_RST 8'h00

// ==========================================================
// behaviour codes and duty levels
`define CODE_FULL 3'h3
`define CODE_OFF 3'h4
`define CODE_MANUAL 3'h7
`define DUTY_FULL 8'hff
`define DUTY_ZERO 8'h00

// ==========================================================
// span decode, hundredths of a degree, code 15 in the top slot
`define SPAN_CENTI_LUT {14'h1f40, 14'h14d5, 14'h0fa0, 14'h0c80, 14'h0a6b, 14'h07d0, \
  14'h0640, 14'h0535, 14'h03e8, 14'h0320, 14'h029b, 14'h01f4, 14'h0190, 14'h014d, \
  14'h00fa, 14'h00c8}
`define SPAN_ENTRY_W 8'h0e
`define SPAN_CODE_MIN 4'h0
`define SPAN_CODE_MAX 4'hf
`define SPAN_CENTI_MIN 14'h00c8
`define SPAN_CENTI_MAX 14'h1f40

// ==========================================================
// ramp steps per slot, code 7 in the top byte
`define RAMP_STEP_LUT {8'h30, 8'h18, 8'h0c, 8'h08, 8'h05, 8'h03, 8'h02, 8'h01}
`define CLK_PERIOD_NS 4
`define RAMP_SLOT_NS 204700000
`define RAMP_SLOT_CYCLES (`RAMP_SLOT_NS / `CLK_PERIOD_NS)

// ==========================================================
// speed sense sync set: bit 0 sense 2, bit 1 sense 3, bit 2 sense 4
`define SENSE_ALL 3'h7
`define SENSE_BASE 3'h6

`endif

// >>> src/fan_pwm_pkg.sv
package fan_pwm_pkg;

  typedef logic [7:0] duty_t;

  typedef struct packed {
    logic [2:0] floor_sel;
    logic align;
    logic ramp_en;
    logic [2:0] rate;
  } acoustic_cfg_t;

  typedef struct packed {
    logic [31:0] cnt;
    duty_t duty;
  } ramp_state_t;

  typedef struct packed {
    logic below;
    duty_t duty;
  } sel_state_t;

  typedef struct packed {
    logic waitreq;
    logic [31:0] rdata;
    acoustic_cfg_t acoustic;
    logic [2:0][3:0] span;
    logic [2:0][2:0] behav;
    logic [2:0][7:0] man;
    logic [2:0][13:0] slope;
    logic [2:0] sense_sync;
  } ctrl_state_t;

endpackage

// >>> src/ramp_if.sv
`timescale 1ns/1ps
`default_nettype none

interface ramp_if;
  logic [7:0] target;
  logic en;
  logic [2:0] rate;
  logic [7:0] duty;
  logic busy;
  modport ctrl (output target, output en, output rate, input duty, input busy);
  modport ramp (input target, input en, input rate, output duty, output busy);
endinterface

`default_nettype wire

// >>> src/acoustic_ramp.sv
`timescale 1ns/1ps
`default_nettype none
`include "fan_pwm_regs.svh"

module acoustic_ramp
  import fan_pwm_pkg::*;
#(
  parameter int unsigned SLOT_CYCLES = `RAMP_SLOT_CYCLES
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // ramp carrier
  ramp_if.ramp bus
);
  localparam logic [63:0] STEP_LUT = `RAMP_STEP_LUT;
  localparam logic [31:0] SLOT_LAST = 32'(SLOT_CYCLES - 1);

  ramp_state_t st;
  ramp_state_t next_st;
  logic tick;
  duty_t step;

  assign tick = (st.cnt == SLOT_LAST);
  assign step = STEP_LUT[{bus.rate, 3'h0} +: 8];

  // ==========================================================
  // slot timer and stepping
  always_comb begin
    next_st = st;
    next_st.cnt = tick ? 32'h0 : st.cnt + 32'h1;
    if (!bus.en) begin
      next_st.duty = bus.target;
    end else if (tick) begin
      if (st.duty < bus.target) begin
        next_st.duty = (duty_t'(bus.target - st.duty) <= step) ? bus.target
                                                               : duty_t'(st.duty + step);
      end else if (st.duty > bus.target) begin
        next_st.duty = (duty_t'(st.duty - bus.target) <= step) ? bus.target
                                                               : duty_t'(st.duty - step);
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign bus.duty = st.duty;
  assign bus.busy = bus.en && (st.duty != bus.target);

  // ==========================================================
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  ramp_bypass_a: assert property (!bus.en |=> bus.duty == $past(bus.target))
    else $error("ramp off but drive did not follow target");
  slot_only_a: assert property ($past(bus.en) && bus.duty != $past(bus.duty) |-> $past(tick))
    else $error("ramped drive moved outside a slot");
  step_size_a: assert property ($past(bus.en) && bus.duty > $past(bus.duty)
      |-> duty_t'(bus.duty - $past(bus.duty)) <= $past(step))
    else $error("ramp step larger than selected rate");
  no_overshoot_a: assert property ($past(bus.en) && $past(bus.duty) < $past(bus.target)
      |-> bus.duty <= $past(bus.target))
    else $error("ramp overshot its target");
  ramp_done_c: cover property (bus.en && $past(bus.busy) && !bus.busy);
  ramp_down_c: cover property (bus.en && tick && st.duty > bus.target);

endmodule

`default_nettype wire

// >>> src/duty_select.sv
`timescale 1ns/1ps
`default_nettype none
`include "fan_pwm_regs.svh"

module duty_select
  import fan_pwm_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // configuration
  input wire logic [2:0] i_code,
  input wire logic [7:0] i_man,
  input wire logic i_floor,
  // link from the control loop
  input wire logic [7:0] i_target,
  input wire logic [7:0] i_min,
  input wire logic [7:0] i_temp,
  input wire logic [7:0] i_tmin,
  input wire logic [7:0] i_hyst,
  // result
  output logic [7:0] o_duty,
  output logic o_below
);
  sel_state_t st;
  sel_state_t next_st;
  logic is_auto;
  logic thresh_ok;
  logic [7:0] low_level;

  assign is_auto = (i_code != `CODE_FULL) && (i_code != `CODE_OFF) && (i_code != `CODE_MANUAL);
  assign thresh_ok = (i_tmin >= i_hyst);
  assign low_level = 8'(i_tmin - i_hyst);

  // ==========================================================
  // below-threshold tracking and duty choice
  always_comb begin
    next_st = st;
    next_st.below = st.below ? (i_temp < i_tmin) : (thresh_ok && (i_temp < low_level));
    case (i_code)
      `CODE_FULL: next_st.duty = `DUTY_FULL;
      `CODE_OFF: next_st.duty = `DUTY_ZERO;
      `CODE_MANUAL: next_st.duty = i_man;
      default: next_st.duty = st.below ? (i_floor ? i_min : `DUTY_ZERO) : i_target;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_duty = st.duty;
  assign o_below = st.below;

  // ==========================================================
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  floor_off_a: assert property (is_auto && st.below && !i_floor |=> o_duty == `DUTY_ZERO)
    else $error("below threshold without floor did not stop the fan");
  floor_min_a: assert property (is_auto && st.below && i_floor |=> o_duty == $past(i_min))
    else $error("below threshold with floor did not hold minimum duty");
  manual_follow_a: assert property (i_code == `CODE_MANUAL |=> o_duty == $past(i_man))
    else $error("manual code did not drive the written duty");
  below_c: cover property (is_auto && st.below && !i_floor);

endmodule

`default_nettype wire

// >>> src/fan_pwm_acoustic_ramp.sv
// The Avalon-MM register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "fan_pwm_regs.svh"

// ==========================================================

module fan_pwm_acoustic_ramp
  import fan_pwm_pkg::*;
#(
  parameter int unsigned SLOT_CYCLES = `RAMP_SLOT_CYCLES
) (
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  // avalon-mm slave
  input wire logic [4:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  // link from the control loop, one entry per drive output
  input wire logic [2:0][7:0] I_TARGET_DUTY,
  input wire logic [2:0][7:0] I_MIN_DUTY,
  input wire logic [2:0][7:0] I_CTRL_TEMP,
  input wire logic [2:0][7:0] I_TMIN,
  input wire logic [2:0][7:0] I_HYST,
  // fan drive duty outputs
  output logic [7:0] O_FAN_DRIVE_1,
  output logic [7:0] O_FAN_DRIVE_2,
  output logic [7:0] O_FAN_DRIVE_3,
  // slope and speed sense alignment
  output logic [2:0][13:0] O_TEMP_SPAN_CENTI,
  output logic [2:0] O_SENSE_SYNC
);
  localparam logic [223:0] SPAN_LUT = `SPAN_CENTI_LUT;

  ctrl_state_t s;
  ctrl_state_t next_s;
  logic rd_hit;
  logic wr_hit;
  logic [31:0] rd_word;
  logic [31:0] wr_word;
  logic [2:0][7:0] sel_duty;
  logic [2:0] sel_below;

  ramp_if rif();

  // ==========================================================
  // byte-lane merge for partial writes
  function automatic logic [31:0] merge_lanes(input logic [31:0] old_word,
                                              input logic [31:0] new_word,
                                              input logic [3:0] lanes);
    logic [31:0] m;
    m = old_word;
    for (int b = 0; b < 4; b++) begin
      if (lanes[b]) begin
        m[8*b +: 8] = new_word[8*b +: 8];
      end
    end
    return m;
  endfunction

  // one wait state: request seen with waitrequest high, answered next cycle
  assign rd_hit = I_AVS_READ && s.waitreq;
  assign wr_hit = I_AVS_WRITE && !s.waitreq;

  // ==========================================================
  // register read view
  always_comb begin
    rd_word = 32'h0;
    case (I_AVS_ADDRESS)
      `ACOUSTIC_CFG_OFS: rd_word = {24'h0, s.acoustic};
      `SPAN_CFG_OFS: rd_word = {20'h0, s.span};
      `BEHAV_CFG_OFS: rd_word = {23'h0, s.behav};
      `MAN_DUTY1_OFS: rd_word = {24'h0, s.man[0]};
      `MAN_DUTY2_OFS: rd_word = {24'h0, s.man[1]};
      `MAN_DUTY3_OFS: rd_word = {24'h0, s.man[2]};
      `STATUS_OFS: rd_word = {4'h0, sel_below, rif.busy, sel_duty[2], sel_duty[1], rif.duty};
      default: rd_word = 32'h0;
    endcase
  end

  assign wr_word = merge_lanes(rd_word, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);

  // ==========================================================
  // next state
  always_comb begin
    next_s = s;
    next_s.waitreq = !((I_AVS_READ || I_AVS_WRITE) && s.waitreq);
    if (rd_hit) begin
      next_s.rdata = rd_word;
    end
    if (wr_hit) begin
      case (I_AVS_ADDRESS)
        `ACOUSTIC_CFG_OFS: next_s.acoustic = acoustic_cfg_t'(wr_word[7:0]);
        `SPAN_CFG_OFS: next_s.span = wr_word[11:0];
        `BEHAV_CFG_OFS: next_s.behav = wr_word[8:0];
        `MAN_DUTY1_OFS: begin
          if (s.behav[0] == `CODE_MANUAL) begin
            next_s.man[0] = wr_word[7:0];
          end
        end
        `MAN_DUTY2_OFS: begin
          if (s.behav[1] == `CODE_MANUAL) begin
            next_s.man[1] = wr_word[7:0];
          end
        end
        `MAN_DUTY3_OFS: begin
          if (s.behav[2] == `CODE_MANUAL) begin
            next_s.man[2] = wr_word[7:0];
          end
        end
        default: begin
        end
      endcase
    end
    // span code to degrees of the duty ramp, in hundredths
    for (int i = 0; i < 3; i++) begin
      next_s.slope[i] = SPAN_LUT[8'(s.span[i]) * `SPAN_ENTRY_W +: 14];
    end
    next_s.sense_sync = s.acoustic.align ? `SENSE_ALL : `SENSE_BASE;
  end

  // ==========================================================
  // state register
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      s.waitreq <= 1'b1;
      s.rdata <= 32'h0;
      s.acoustic <= acoustic_cfg_t'(`ACOUSTIC_CFG_RST);
      s.span <= `SPAN_CFG_RST;
      s.behav <= `BEHAV_CFG_RST;
      s.man <= {3{`MAN_DUTY_RST}};
      s.slope <= {3{`SPAN_CENTI_MIN}};
      s.sense_sync <= `SENSE_BASE;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // per-output duty choice
  for (genvar g = 0; g < 3; g++) begin : g_sel
    duty_select u_sel (
      .i_clk(I_CLK_SYS),
      .i_rst(I_RST),
      .i_code(s.behav[g]),
      .i_man(s.man[g]),
      .i_floor(s.acoustic.floor_sel[g]),
      .i_target(I_TARGET_DUTY[g]),
      .i_min(I_MIN_DUTY[g]),
      .i_temp(I_CTRL_TEMP[g]),
      .i_tmin(I_TMIN[g]),
      .i_hyst(I_HYST[g]),
      .o_duty(sel_duty[g]),
      .o_below(sel_below[g])
    );
  end

  // ==========================================================
  // acoustic ramp on drive output 1
  assign rif.target = sel_duty[0];
  assign rif.en = s.acoustic.ramp_en;
  assign rif.rate = s.acoustic.rate;

  acoustic_ramp #(
    .SLOT_CYCLES(SLOT_CYCLES)
  ) u_ramp (
    .i_clk(I_CLK_SYS),
    .i_rst(I_RST),
    .bus(rif.ramp)
  );

  // ==========================================================
  // outputs
  assign O_AVS_READDATA = s.rdata;
  assign O_AVS_WAITREQUEST = s.waitreq;
  assign O_FAN_DRIVE_1 = rif.duty;
  assign O_FAN_DRIVE_2 = sel_duty[1];
  assign O_FAN_DRIVE_3 = sel_duty[2];
  assign O_TEMP_SPAN_CENTI = s.slope;
  assign O_SENSE_SYNC = s.sense_sync;

  // ==========================================================
  // checks
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);

  bus_answer_a: assert property ((I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST
      |=> !O_AVS_WAITREQUEST)
    else $error("request not answered after one wait state");
  bus_release_a: assert property (!O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST)
    else $error("waitrequest stayed low for two cycles");
  span_top_a: assert property (s.span[0] == `SPAN_CODE_MAX
      |=> O_TEMP_SPAN_CENTI[0] == `SPAN_CENTI_MAX)
    else $error("top span code did not decode to 80 degrees");
  span_bottom_a: assert property (s.span[2] == `SPAN_CODE_MIN
      |=> O_TEMP_SPAN_CENTI[2] == `SPAN_CENTI_MIN)
    else $error("bottom span code did not decode to 2 degrees");
  sync_all_a: assert property (s.acoustic.align |=> O_SENSE_SYNC == `SENSE_ALL)
    else $error("align set but sense 2 not in sync set");
  sync_base_a: assert property (!s.acoustic.align |=> O_SENSE_SYNC == `SENSE_BASE)
    else $error("align clear but sync set not senses 3 and 4");
  manual_lock_a: assert property (wr_hit && I_AVS_ADDRESS == `MAN_DUTY2_OFS
      && s.behav[1] != `CODE_MANUAL |=> s.man[1] == $past(s.man[1]))
    else $error("duty register written outside manual mode");
  manual_write_a: assert property (wr_hit && I_AVS_ADDRESS == `MAN_DUTY2_OFS
      && s.behav[1] == `CODE_MANUAL && I_AVS_BYTEENABLE[0]
      |=> s.man[1] == $past(I_AVS_WRITEDATA[7:0]))
    else $error("manual duty write lost");
  readback_a: assert property (rd_hit && I_AVS_ADDRESS == `ACOUSTIC_CFG_OFS
      |=> O_AVS_READDATA == {24'h0, $past(s.acoustic)})
    else $error("acoustic register read back wrong");

  manual_wr_c: cover property (wr_hit && I_AVS_ADDRESS == `MAN_DUTY2_OFS
      && s.behav[1] == `CODE_MANUAL);
  ramp_on_c: cover property (s.acoustic.ramp_en && rif.busy);

endmodule

`default_nettype wire

// >>> verif/fan_model.sv
`timescale 1ns/1ps
`default_nettype none

module fan_model (
  // clock
  input wire logic i_clk,
  // drive duties, index 0 = fan 1
  input wire logic [2:0][7:0] i_duty,
  // modelled fan speed
  output logic [2:0][7:0] o_speed
);
  // ==========================================================
  // rotor inertia: speed creeps one count per clock toward duty
  initial o_speed = '0;
  always @(posedge i_clk) begin
    for (int i = 0; i < 3; i++) begin
      if (o_speed[i] < i_duty[i]) begin
        o_speed[i] <= o_speed[i] + 8'h01;
      end else if (o_speed[i] > i_duty[i]) begin
        o_speed[i] <= o_speed[i] - 8'h01;
      end
    end
  end
endmodule

`default_nettype wire

// >>> verif/fan_pwm_acoustic_ramp_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "fan_pwm_regs.svh"

module fan_pwm_acoustic_ramp_test
  import fan_pwm_pkg::*;
();
  localparam int SLOT = 4;
  localparam logic [7:0] STEP [8] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h08, 8'h0c, 8'h18, 8'h30};
  localparam logic [13:0] SPAN [16] = '{14'h00c8, 14'h00fa, 14'h014d, 14'h0190, 14'h01f4,
    14'h029b, 14'h0320, 14'h03e8, 14'h0535, 14'h0640, 14'h07d0, 14'h0a6b, 14'h0c80,
    14'h0fa0, 14'h14d5, 14'h1f40};

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] addr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'hf;
  logic [31:0] rdata;
  logic waitreq;
  logic [2:0][7:0] tgt = {8'ha0, 8'h90, 8'h80};
  logic [2:0][7:0] mind = {8'h22, 8'h21, 8'h20};
  logic [2:0][7:0] temp = {8'h50, 8'h50, 8'h50};
  logic [2:0][7:0] tmin = {8'h40, 8'h40, 8'h40};
  logic [2:0][7:0] hyst = {8'h08, 8'h08, 8'h08};
  logic [7:0] d1, d2, d3;
  logic [2:0][13:0] span;
  logic [2:0] sync;
  logic [2:0][7:0] speed;
  int errors = 0;
  int n_tests = 0;

  always #2 clk = ~clk;

  fan_pwm_acoustic_ramp #(.SLOT_CYCLES(SLOT)) u_dut (
    .I_CLK_SYS(clk), .I_RST(rst), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd),
    .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(be),
    .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(waitreq), .I_TARGET_DUTY(tgt),
    .I_MIN_DUTY(mind), .I_CTRL_TEMP(temp), .I_TMIN(tmin), .I_HYST(hyst),
    .O_FAN_DRIVE_1(d1), .O_FAN_DRIVE_2(d2), .O_FAN_DRIVE_3(d3),
    .O_TEMP_SPAN_CENTI(span), .O_SENSE_SYNC(sync));

  fan_model u_fans (.i_clk(clk), .i_duty({d3, d2, d1}), .o_speed(speed));

  // ==========================================================
  // common tasks
  task automatic wrap_up;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    rd <= !w;
    wr <= w;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    q = rdata;
    if (waitreq !== 1'b0) begin
      errors++;
      wrap_up();
    end
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input string name, input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(name, exp, q);
  endtask

  task automatic settle;
    repeat (4) @(posedge clk);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset;
    rd_chk("acoustic reset", `ACOUSTIC_CFG_OFS, 32'h0);
    rd_chk("span reset", `SPAN_CFG_OFS, 32'hccc);
    rd_chk("behaviour reset", `BEHAV_CFG_OFS, 32'h0db);
    rd_chk("manual duty reset", `MAN_DUTY1_OFS, 32'h0);
    rd_chk("unmapped read", 5'h1c, 32'h0);
    for (int c = 0; c < 3; c++) chk("span out reset", 32'h0c80, 32'(span[c]));
    chk("sense sync reset", 32'h6, 32'(sync));
    chk("drive 1 full", 32'hff, 32'(d1));
    chk("drive 3 full", 32'hff, 32'(d3));
  endtask

  task automatic t_span;
    for (int c = 0; c < 16; c++) begin
      wr_reg(`SPAN_CFG_OFS, {20'h0, 4'(c), 4'(c), 4'(c)});
      settle();
      for (int k = 0; k < 3; k++) chk("span decode", 32'(SPAN[c]), 32'(span[k]));
    end
  endtask

  task automatic t_sync;
    wr_reg(`ACOUSTIC_CFG_OFS, 32'h10);
    settle();
    chk("sense sync all", 32'h7, 32'(sync));
    wr_reg(`ACOUSTIC_CFG_OFS, 32'h0);
    settle();
    chk("sense sync base", 32'h6, 32'(sync));
  endtask

  task automatic t_floor;
    wr_reg(`BEHAV_CFG_OFS, 32'h0);
    for (int f = 0; f < 8; f++) begin
      wr_reg(`ACOUSTIC_CFG_OFS, 32'(f) << 5);
      temp <= {8'h20, 8'h20, 8'h20};
      settle();
      chk("drive 1 floor", f[0] ? 32'(mind[0]) : 32'h0, 32'(d1));
      chk("drive 2 floor", f[1] ? 32'(mind[1]) : 32'h0, 32'(d2));
      chk("drive 3 floor", f[2] ? 32'(mind[2]) : 32'h0, 32'(d3));
      temp <= {8'h3c, 8'h3c, 8'h3c};
      settle();
      chk("drive 2 in band", f[1] ? 32'(mind[1]) : 32'h0, 32'(d2));
      temp <= {8'h50, 8'h50, 8'h50};
      settle();
      chk("drive 1 above", 32'(tgt[0]), 32'(d1));
      chk("drive 3 above", 32'(tgt[2]), 32'(d3));
    end
    temp <= {8'h3c, 8'h3c, 8'h3c};
    settle();
    chk("drive 2 band from above", 32'(tgt[1]), 32'(d2));
    temp <= {8'h50, 8'h50, 8'h50};
    settle();
    rd_chk("status", `STATUS_OFS, 32'h00a09080);
  endtask

  task automatic t_manual;
    wr_reg(`MAN_DUTY2_OFS, 32'h5a);
    rd_chk("manual write refused", `MAN_DUTY2_OFS, 32'h0);
    wr_reg(`BEHAV_CFG_OFS, 32'h038);
    wr_reg(`MAN_DUTY2_OFS, 32'h5a);
    settle();
    chk("drive 2 manual", 32'h5a, 32'(d2));
    rd_chk("manual duty readback", `MAN_DUTY2_OFS, 32'h5a);
    wr_reg(`BEHAV_CFG_OFS, 32'h0);
  endtask

  task automatic ramp_to(input logic [7:0] t, input logic [7:0] st);
    logic [7:0] prev;
    logic [7:0] exp;
    int n;
    n = 0;
    @(posedge clk);
    prev = d1;
    tgt[0] <= t;
    while (d1 !== t && n < 1000) begin
      @(negedge clk);
      n++;
      if (d1 !== prev) begin
        if (t > prev) exp = (t - prev > st) ? prev + st : t;
        else exp = (prev - t > st) ? prev - st : t;
        chk("drive 1 step", 32'(exp), 32'(d1));
        prev = d1;
      end
    end
    if (n >= 1000) begin
      errors++;
      wrap_up();
    end
  endtask

  task automatic t_ramp;
    tgt[0] <= 8'h10;
    settle();
    tgt[0] <= 8'hf0;
    settle();
    chk("drive 1 unramped", 32'hf0, 32'(d1));
    tgt[0] <= 8'h10;
    settle();
    for (int r = 0; r < 8; r++) begin
      wr_reg(`ACOUSTIC_CFG_OFS, 32'h08 | 32'(r));
      ramp_to(8'h74, STEP[r]);
      ramp_to(8'h10, STEP[r]);
    end
    wr_reg(`ACOUSTIC_CFG_OFS, 32'h0);
    tgt[0] <= 8'he0;
    settle();
    chk("drive 1 ramp off", 32'he0, 32'(d1));
    chk("fan 2 speed", 32'(tgt[1]), 32'(speed[1]));
    chk("fan 3 speed", 32'(tgt[2]), 32'(speed[2]));
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    settle();
    t_reset();
    t_span();
    t_sync();
    t_floor();
    t_manual();
    t_ramp();
    wrap_up();
  end
endmodule

`default_nettype wire
